// >>> rtl/adc_event_control.sv
// Purpose: Event-interface control of a converter: output gating, input
//          invert and enable, slave override
// Assumes: Events and core strobes are one-cycle pulses on clk_sys
// Notes:   Registers reached over a plain strobe port, read data next cycle
// Function
// - Window-monitor detections leave as events only when bit 5 is set.
// - Result-ready strobes leave as events only when bit 4 is set.
// - Bit 3 inverts the incoming start event source before use.
// - Bit 2 inverts the incoming flush event source before use.
// - Bit 1 lets incoming start events begin a conversion.
// - In slave operation, start invert, flush invert and start enable are ignored.
// - Event control is 6 bits at offset 0x02, all bits reset zero.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module adc_event_control (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        start_event_in,
  input  wire logic        flush_event_in,
  input  wire logic        result_ready,
  input  wire logic        window_detect,
  output logic             start_conversion,
  output logic             flush_pipeline,
  output logic             result_ready_event_out,
  output logic             window_event_out
);
  localparam int EW = adc_event_pkg::ADC_EVENT_CONTROL_W;

  logic [EW-1:0] adc_event_control_q;
  logic          slave_q;
  logic [7:0]    rdata_q;
  logic          window_out_q;
  logic          resrdy_out_q;
  logic          wr_adc_event_control;
  logic          wr_ctrl;
  logic          start_inv_eff;
  logic          flush_inv_eff;
  logic          start_en_eff;
  logic          flush_en_eff;

  event_cond_if start_ch ();
  event_cond_if flush_ch ();

  assign wr_adc_event_control = reg_wr && (reg_addr == adc_event_pkg::ADC_EVENT_CONTROL_OFFSET);
  assign wr_ctrl   = reg_wr && (reg_addr == adc_event_pkg::CTRL_OFFSET);

  // Event control register, bits 7:6 not implemented
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      adc_event_control_q <= adc_event_pkg::ADC_EVENT_CONTROL_RESET;
    end else if (wr_adc_event_control) begin
      adc_event_control_q <= reg_wdata[EW-1:0];
    end
  end

  // Slave operation select in the control register
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      slave_q <= adc_event_pkg::SLAVE_RESET;
    end else if (wr_ctrl) begin
      slave_q <= reg_wdata[adc_event_pkg::SLAVE_EN_BIT];
    end
  end

  // Slave override; flush enable stays honoured since only three bits are masked
  assign start_inv_eff = ~slave_q & adc_event_control_q[adc_event_pkg::START_INV_BIT];
  assign flush_inv_eff = ~slave_q & adc_event_control_q[adc_event_pkg::FLUSH_INV_BIT];
  assign start_en_eff  = ~slave_q & adc_event_control_q[adc_event_pkg::START_EI_BIT];
  assign flush_en_eff  = adc_event_control_q[adc_event_pkg::FLUSH_EI_BIT];

  // Channel wiring into the conditioners
  assign start_ch.src    = start_event_in;
  assign start_ch.invert = start_inv_eff;
  assign start_ch.enable = start_en_eff;
  assign flush_ch.src    = flush_event_in;
  assign flush_ch.invert = flush_inv_eff;
  assign flush_ch.enable = flush_en_eff;

  event_input_conditioner u_start_cond (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .ch      (start_ch.cond)
  );

  event_input_conditioner u_flush_cond (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .ch      (flush_ch.cond)
  );

  // Conversion and flush requests leave straight from the conditioner flops
  assign start_conversion = start_ch.pulse;
  assign flush_pipeline   = flush_ch.pulse;

  // Window-monitor event gating
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      window_out_q <= 1'b0;
    end else begin
      window_out_q <= window_detect & adc_event_control_q[adc_event_pkg::WINDOW_EO_BIT];
    end
  end

  // Result-ready event gating
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      resrdy_out_q <= 1'b0;
    end else begin
      resrdy_out_q <= result_ready & adc_event_control_q[adc_event_pkg::RESRDY_EO_BIT];
    end
  end

  assign window_event_out       = window_out_q;
  assign result_ready_event_out = resrdy_out_q;

  // Read data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rdata_q <= adc_event_pkg::READ_IDLE;
    end else if (reg_rd) begin
      case (reg_addr)
        adc_event_pkg::ADC_EVENT_CONTROL_OFFSET: rdata_q <= {2'h0, adc_event_control_q};
        adc_event_pkg::CTRL_OFFSET:   rdata_q <= {7'h00, slave_q};
        adc_event_pkg::STATUS_OFFSET: begin
          rdata_q <= {5'h00, slave_q, flush_ch.level, start_ch.level};
        end
        default:                      rdata_q <= adc_event_pkg::READ_IDLE;
      endcase
    end else begin
      rdata_q <= adc_event_pkg::READ_IDLE;
    end
  end

  assign reg_rdata = rdata_q;

  // Checks

  sequence s_start_edge;
    !(start_event_in ^ start_inv_eff)
    ##1 ((start_event_in ^ start_inv_eff) && start_en_eff);
  endsequence

  sequence s_flush_edge;
    !(flush_event_in ^ flush_inv_eff)
    ##1 ((flush_event_in ^ flush_inv_eff) && flush_en_eff);
  endsequence

  property p_window_gate;
    @(posedge clk_sys) disable iff (!resetn)
    window_event_out |-> $past(window_detect) && $past(adc_event_control_q[5]);
  endproperty
  a_window_gate: assert property (p_window_gate)
    else $error("window event out without enabled detection");

  property p_window_pass;
    @(posedge clk_sys) disable iff (!resetn)
    (window_detect && adc_event_control_q[5]) |=> window_event_out;
  endproperty
  a_window_pass: assert property (p_window_pass)
    else $error("enabled window detection produced no event");

  property p_resrdy;
    @(posedge clk_sys) disable iff (!resetn)
    ##1 (result_ready_event_out == $past(result_ready && adc_event_control_q[4]));
  endproperty
  a_resrdy: assert property (p_resrdy)
    else $error("result ready event gating wrong");

  property p_start_edge;
    @(posedge clk_sys) disable iff (!resetn)
    s_start_edge |=> start_conversion;
  endproperty
  a_start_edge: assert property (p_start_edge)
    else $error("conditioned start edge did not start a conversion");

  property p_start_disabled;
    @(posedge clk_sys) disable iff (!resetn)
    !start_en_eff |=> !start_conversion;
  endproperty
  a_start_disabled: assert property (p_start_disabled)
    else $error("conversion started with start input disabled");

  property p_slave_block;
    @(posedge clk_sys) disable iff (!resetn)
    slave_q |=> !start_conversion;
  endproperty
  a_slave_block: assert property (p_slave_block)
    else $error("start event acted in slave operation");

  property p_flush_edge;
    @(posedge clk_sys) disable iff (!resetn)
    s_flush_edge |=> flush_pipeline;
  endproperty
  a_flush_edge: assert property (p_flush_edge)
    else $error("conditioned flush edge did not flush");

  property p_flush_disabled;
    @(posedge clk_sys) disable iff (!resetn)
    !flush_en_eff |=> !flush_pipeline;
  endproperty
  a_flush_disabled: assert property (p_flush_disabled)
    else $error("flush with flush input disabled");

  property p_reset_zero;
    @(posedge clk_sys)
    !resetn |=> (adc_event_control_q == 6'h00) && !window_event_out && !start_conversion;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("event control not cleared by reset");

  // Slave flush path: inversion masked, so the raw rising level must act
  sequence s_slave_flush_rise;
    (slave_q && flush_en_eff && !flush_event_in)
    ##1 (slave_q && flush_en_eff && flush_event_in);
  endsequence

  // Inverted start source: a falling raw level is the acting edge
  sequence s_start_fall_inv;
    (start_inv_eff && start_en_eff && start_event_in)
    ##1 (start_inv_eff && start_en_eff && !start_event_in);
  endsequence

  property p_window_block;
    @(posedge clk_sys) disable iff (!resetn)
    !adc_event_control_q[adc_event_pkg::WINDOW_EO_BIT] |=> !window_event_out;
  endproperty
  a_window_block: assert property (p_window_block)
    else $error("window event left while its output was disabled");

  property p_resrdy_block;
    @(posedge clk_sys) disable iff (!resetn)
    !adc_event_control_q[adc_event_pkg::RESRDY_EO_BIT] |=> !result_ready_event_out;
  endproperty
  a_resrdy_block: assert property (p_resrdy_block)
    else $error("result ready event left while its output was disabled");

  property p_start_inv_fall;
    @(posedge clk_sys) disable iff (!resetn)
    s_start_fall_inv |=> start_conversion;
  endproperty
  a_start_inv_fall: assert property (p_start_inv_fall)
    else $error("inverted start source fall did not start a conversion");

  property p_start_cause;
    @(posedge clk_sys) disable iff (!resetn)
    start_conversion |-> $past(start_en_eff);
  endproperty
  a_start_cause: assert property (p_start_cause)
    else $error("conversion started without an enabled start input");

  property p_start_once;
    @(posedge clk_sys) disable iff (!resetn)
    start_conversion |=> !start_conversion;
  endproperty
  a_start_once: assert property (p_start_once)
    else $error("start request stood longer than one cycle");

  property p_flush_cause;
    @(posedge clk_sys) disable iff (!resetn)
    flush_pipeline |-> $past(flush_en_eff);
  endproperty
  a_flush_cause: assert property (p_flush_cause)
    else $error("flush issued without an enabled flush input");

  property p_flush_once;
    @(posedge clk_sys) disable iff (!resetn)
    flush_pipeline |=> !flush_pipeline;
  endproperty
  a_flush_once: assert property (p_flush_once)
    else $error("flush request stood longer than one cycle");

  property p_slave_invert;
    @(posedge clk_sys) disable iff (!resetn)
    slave_q |-> (!start_inv_eff && !flush_inv_eff && !start_en_eff);
  endproperty
  a_slave_invert: assert property (p_slave_invert)
    else $error("slave operation left an input setting in force");

  property p_slave_flush;
    @(posedge clk_sys) disable iff (!resetn)
    s_slave_flush_rise |=> flush_pipeline;
  endproperty
  a_slave_flush: assert property (p_slave_flush)
    else $error("flush enable not honoured in slave operation");

  property p_adc_event_control_write;
    @(posedge clk_sys) disable iff (!resetn)
    wr_adc_event_control |=> (adc_event_control_q == $past(reg_wdata[EW-1:0]));
  endproperty
  a_adc_event_control_write: assert property (p_adc_event_control_write)
    else $error("event control write did not land");

  property p_adc_event_control_hold;
    @(posedge clk_sys) disable iff (!resetn)
    !wr_adc_event_control |=> $stable(adc_event_control_q);
  endproperty
  a_adc_event_control_hold: assert property (p_adc_event_control_hold)
    else $error("event control changed without a write");

  property p_read_adc_event_control;
    @(posedge clk_sys) disable iff (!resetn)
    (reg_rd && (reg_addr == adc_event_pkg::ADC_EVENT_CONTROL_OFFSET))
    |=> (reg_rdata == {2'h0, $past(adc_event_control_q)});
  endproperty
  a_read_adc_event_control: assert property (p_read_adc_event_control)
    else $error("event control read returned wrong data");

  property p_read_idle;
    @(posedge clk_sys) disable iff (!resetn)
    !reg_rd |=> (reg_rdata == 8'h00);
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read data stood outside its cycle");

endmodule : adc_event_control
`default_nettype wire

// >>> include/adc_event_pkg.sv
// Purpose: Shared constants for the converter event-control block
// Assumes: 8-bit register port, byte offsets as printed
// Notes:   Every offset, field position and reset value lives here
`default_nettype none
package adc_event_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h01;
  localparam logic [7:0] ADC_EVENT_CONTROL_OFFSET = 8'h02;

  // Event control field positions
  localparam int WINDOW_EO_BIT   = 5;
  localparam int RESRDY_EO_BIT   = 4;
  localparam int START_INV_BIT   = 3;
  localparam int FLUSH_INV_BIT   = 2;
  localparam int START_EI_BIT    = 1;
  localparam int FLUSH_EI_BIT    = 0;
  localparam int ADC_EVENT_CONTROL_W        = 6;

  // Control and status field positions
  localparam int SLAVE_EN_BIT    = 0;
  localparam int STAT_START_BIT  = 0;
  localparam int STAT_FLUSH_BIT  = 1;
  localparam int STAT_SLAVE_BIT  = 2;

  // Reset values
  localparam logic [ADC_EVENT_CONTROL_W-1:0] ADC_EVENT_CONTROL_RESET = 6'h00;
  localparam logic                SLAVE_RESET  = 1'b0;
  localparam logic [7:0]          READ_IDLE    = 8'h00;
endpackage : adc_event_pkg
`default_nettype wire

// >>> include/event_cond_if.sv
// Purpose: Bundle between the control top and one event input conditioner
// Assumes: Single clock, all signals on clk_sys
// Notes:   One instance per incoming event channel
`timescale 1ns/1ps
`default_nettype none
interface event_cond_if;
  logic src;     // Raw event level from the routing network
  logic invert;  // Effective invert select
  logic enable;  // Effective input enable
  logic pulse;   // One-cycle action request
  logic level;   // Registered conditioned level

  modport cond  (input src, input invert, input enable, output pulse, output level);
  modport owner (output src, output invert, output enable, input pulse, input level);
endinterface : event_cond_if
`default_nettype wire

// >>> rtl/event_input_conditioner.sv
// Purpose: Invert and edge-detect one incoming event, gated by its enable
// Assumes: Source is on clk_sys, no synchroniser needed
// Notes:   Toggling invert while idle is itself an edge, as in the real part
`timescale 1ns/1ps
`default_nettype none
module event_input_conditioner (
  input  wire logic    clk_sys,
  input  wire logic    resetn,
  event_cond_if.cond   ch
);
  logic eff;

  // Selected polarity applied before detection
  assign eff = ch.src ^ ch.invert;

  // Previous conditioned level for edge detection
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ch.level <= 1'b0;
    end else begin
      ch.level <= eff;
    end
  end

  // Rising edge of the conditioned level, only while enabled
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ch.pulse <= 1'b0;
    end else begin
      ch.pulse <= ch.enable & eff & ~ch.level;
    end
  end
endmodule : event_input_conditioner
`default_nettype wire

// >>> test/core_model.sv
// Purpose: Converter core model facing the event block
// Assumes: Start pulses are one cycle on clk_sys
// Notes:   Each start yields one result and one window strobe
`timescale 1ns/1ps
`default_nettype none
module core_model #(
  parameter int LAT = 3
) (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       start_conversion,
  input  wire logic       flush_pipeline,
  input  wire logic       result_ready_event_out,
  input  wire logic       window_event_out,
  output logic            result_ready,
  output logic            window_detect,
  output logic      [7:0] n_start,
  output logic      [7:0] n_flush,
  output logic      [7:0] n_res,
  output logic      [7:0] n_win
);
  logic [LAT-1:0] conv_q;
  // Fixed latency, so expected event counts stay simple
  always_ff @(posedge clk_sys) begin
    if (!resetn) conv_q <= '0;
    else conv_q <= {conv_q[LAT-2:0], start_conversion};
  end
  assign result_ready  = conv_q[LAT-1];
  assign window_detect = conv_q[LAT-1];
  // Tally what the block hands out
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      n_start <= 8'h00;
      n_flush <= 8'h00;
      n_res   <= 8'h00;
      n_win   <= 8'h00;
    end else begin
      n_start <= n_start + 8'(start_conversion);
      n_flush <= n_flush + 8'(flush_pipeline);
      n_res   <= n_res + 8'(result_ready_event_out);
      n_win   <= n_win + 8'(window_event_out);
    end
  end
endmodule : core_model
`default_nettype wire

// >>> test/adc_event_control_bench.sv
// Purpose: Self-checking bench for the converter event block
// Assumes: Core model answers starts after a fixed latency
// Notes:   Rows set modes; register corners are hand-written
`timescale 1ns/1ps
`default_nettype none
module adc_event_control_bench;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        start_event_in = 1'b0;
  logic        flush_event_in = 1'b0;
  logic [7:0]  reg_rdata;
  logic        rdy, win, st, fl, rdy_o, win_o;
  logic [7:0]  n_start, n_flush, n_res, n_win;
  int          n_mismatch = 0;
  int          checked = 0;
  // Event control, slave, start rise/fall, flush rise/fall, result, window
  logic [14:0] rows [10] = '{{8'h00, 7'h00}, {8'h02, 7'h20}, {8'h0A, 7'h10},
    {8'h01, 7'h08}, {8'h05, 7'h04}, {8'h0E, 7'h40}, {8'h05, 7'h48},
    {8'h32, 7'h23}, {8'h1B, 7'h1A}, {8'h2F, 7'h48}};
  always #12.5 clk_sys = ~clk_sys;
  adc_event_control i_dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .start_event_in(start_event_in), .flush_event_in(flush_event_in),
    .result_ready(rdy), .window_detect(win), .start_conversion(st),
    .flush_pipeline(fl), .result_ready_event_out(rdy_o), .window_event_out(win_o));
  core_model i_core (.clk_sys(clk_sys), .resetn(resetn), .start_conversion(st),
    .flush_pipeline(fl), .result_ready_event_out(rdy_o), .window_event_out(win_o),
    .result_ready(rdy), .window_detect(win), .n_start(n_start), .n_flush(n_flush),
    .n_res(n_res), .n_win(n_win));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic conclude();
    if (n_mismatch == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  // Waits long enough to absorb invert toggles and core latency
  task automatic settle(output logic [7:0] s, f, r, w);
    repeat (8) @(posedge clk_sys);
    #1 {s, f, r, w} = {n_start, n_flush, n_res, n_win};
  endtask : settle
  initial begin
    logic [7:0] d, s0, f0, r0, w0, s1, f1, r1, w1, ev;
    logic [6:0] ex;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(8'h02, d);
    chk("reset value", 8'h00, d);
    wr(8'h02, 8'hFF);
    rd(8'h02, d);
    chk("event control", 8'h3F, d);
    @(posedge clk_sys);
    #1 chk("read data after", 8'h00, reg_rdata);
    rd(8'h07, d);
    chk("unmapped read", 8'h00, d);
    @(posedge clk_sys);
    resetn <= 1'b0;
    @(posedge clk_sys);
    resetn <= 1'b1;
    rd(8'h02, d);
    chk("mid-run reset", 8'h00, d);
    for (int i = 0; i < 10; i++) begin
      {ev, ex} = rows[i];
      wr(8'h00, {7'h00, ex[6]});
      wr(8'h02, ev);
      settle(s0, f0, r0, w0);
      @(posedge clk_sys);
      start_event_in <= 1'b1;
      flush_event_in <= 1'b1;
      settle(s1, f1, r1, w1);
      chk("start on rise", 8'(ex[5]), s1 - s0);
      chk("flush on rise", 8'(ex[3]), f1 - f0);
      @(posedge clk_sys);
      start_event_in <= 1'b0;
      flush_event_in <= 1'b0;
      settle(s0, f0, d, ev);
      chk("start on fall", 8'(ex[4]), s0 - s1);
      chk("flush on fall", 8'(ex[2]), f0 - f1);
      chk("result events", 8'(ex[1]), d - r0);
      chk("window events", 8'(ex[0]), ev - w0);
    end
    wr(8'h01, 8'hFF);
    rd(8'h00, d);
    chk("slave select", 8'h01, d);
    rd(8'h01, d);
    chk("status levels", 8'h04, d);
    conclude();
  end
  // Hang guard, well beyond the expected run
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    conclude();
  end
endmodule : adc_event_control_bench
`default_nettype wire
